// ### shared/asp_defs.vh
// Constants for the asynchronous serial port: register offsets, field
// positions, reset values and bit timing counts.
// Assumes 16-bit word addresses.
//
// What this block does
// RL1 - Bit rate is clock/((divider+1)*8), zero gives /16
// RL2 - Sixteen-bit divider split over high and low bytes
// RL3 - Start, 1-8 data, optional parity, 1-2 stops
// RL4 - Separate parity, overrun, framing and break flags
// RL5 - Holding buffers, own enable and interrupt per path
// RL6 - Transmitter and receiver run independently or together
// RL7 - Transmit ready while holding buffer accepts character
// RL8 - Transmitter empty when shift register holds nothing
// RL9 - Receive ready on held character, break flag
// RL10 - Combined error flag ORs the four errors
// RL11 - Separate interrupt enables, break lacks its own
// RL12 - Idle-line and address-bit wake-up modes
// RL13 - Pins use non-return-to-zero encoding
// RL14 - Data in bits 7-0, upper byte zero
// RL15 - Master uses only 16-bit register accesses
// RL16 - Hardware detects incoming bit rate
// RL17 - Sixteen-level FIFOs with three FIFO registers
// RL18 - Idle high, data least significant bit first
// RL19 - Receiver samples bit centres from start edge
`ifndef ASP_DEFS_VH
`define ASP_DEFS_VH

// Register word addresses
`define ASP_A_CCR       16'h7050
`define ASP_A_CTL1      16'h7051
`define ASP_A_HBAUD     16'h7052
`define ASP_A_LBAUD     16'h7053
`define ASP_A_CTL2      16'h7054
`define ASP_A_RXST      16'h7055
`define ASP_A_RXEMU     16'h7056
`define ASP_A_RXBUF     16'h7057
`define ASP_A_TXBUF     16'h7059
`define ASP_A_FFTX      16'h705a
`define ASP_A_FFRX      16'h705b
`define ASP_A_FFCT      16'h705c
`define ASP_A_PRI       16'h705f

// Reset values
`define ASP_RST_BYTE    8'h00

// comm_control fields
`define ASP_CCR_STOP2   7
`define ASP_CCR_EVEN    6
`define ASP_CCR_PAREN   5
`define ASP_CCR_ADDRMD  3

// port_control_one fields
`define ASP_C1_RXERRIE  6
`define ASP_C1_SWRST_N  5
`define ASP_C1_TXWAKE   3
`define ASP_C1_SLEEP    2
`define ASP_C1_TXEN     1
`define ASP_C1_RXEN     0

// port_control_two fields
`define ASP_C2_TX_HOLDING_FREE    7
`define ASP_C2_TXEMPTY  6
`define ASP_C2_RXIE     1
`define ASP_C2_TXIE     0

// FIFO register fields
`define ASP_FF_EN       7
`define ASP_FF_OVF      7
`define ASP_FF_RST      6
`define ASP_FF_OVFCLR   5
`define ASP_FC_ABDDONE  7
`define ASP_FC_ABDCLR   6
`define ASP_FC_ABDEN    0

// Bit timing
`define ASP_OVS_LAST    3'h7
`define ASP_CENTRE      3'h3
`define ASP_IDLE_TICKS  7'h50
`define ASP_GAP_BITS    4'hb
`define ASP_FIFO_DEPTH  16
`define ASP_FIFO_AW     4

`endif

// ### src/asp_fifo.v
// Byte queue, one instance each for the transmit and receive paths.
// Assumes no push when full and no pop when empty.
`default_nettype none
`include "asp_defs.vh"

module asp_fifo (
    // Clock and reset
    input  wire       ref_clk_i,
    input  wire       rst_n_i,
    // Control
    input  wire       clr_i,
    input  wire       push_i,
    input  wire [7:0] din_i,
    input  wire       pop_i,
    // Status and data
    output wire [7:0] dout_o,
    output wire [4:0] count_o,
    output wire       full_o,
    output wire       empty_o
);

    reg [7:0] mem_r [0:`ASP_FIFO_DEPTH-1];
    reg [3:0] wp_r;
    reg [3:0] rp_r;
    reg [4:0] cnt_r;

    // Storage; no reset needed, contents gated by count
    always @(posedge ref_clk_i) begin
        if (push_i) begin
            mem_r[wp_r] <= din_i;
        end
    end

    // Pointers and fill level
    always @(posedge ref_clk_i) begin
        if (!rst_n_i || clr_i) begin
            wp_r  <= 4'h0;
            rp_r  <= 4'h0;
            cnt_r <= 5'h00;
        end else begin
            if (push_i) begin
                wp_r <= wp_r + 4'h1;
            end
            if (pop_i) begin
                rp_r <= rp_r + 4'h1;
            end
            cnt_r <= cnt_r + {4'h0, push_i} - {4'h0, pop_i};
        end
    end

    assign dout_o  = mem_r[rp_r];
    assign count_o = cnt_r;
    assign full_o  = (cnt_r == 5'h10);
    assign empty_o = (cnt_r == 5'h00);

endmodule
`default_nettype wire

// ### src/asp_top.v
// Asynchronous serial port: register file, baud generator, transmitter,
// receiver, wake-up modes and automatic bit rate detection.
// Assumes inputs synchronous to ref_clk_i, the low-speed peripheral clock.
`default_nettype none
`include "asp_defs.vh"

module asp_top (
    // Clock and reset
    input  wire        ref_clk_i,
    input  wire        rst_n_i,
    // Peripheral register port, 16-bit word accesses
    input  wire [15:0] bus_addr_i,
    input  wire        bus_wr_i,
    input  wire        bus_rd_i,
    input  wire [15:0] bus_wdata_i,
    output reg  [15:0] bus_rdata_o,
    // Serial pins
    input  wire        serial_in_pin_i,
    output reg         serial_out_pin_o,
    // Interrupt requests
    output reg         tx_irq_o,
    output reg         rx_irq_o
);

    localparam S_IDLE = 3'h0;
    localparam S_GAP  = 3'h1;
    localparam S_STRT = 3'h2;
    localparam S_DATA = 3'h3;
    localparam S_ADDR = 3'h4;
    localparam S_PAR  = 3'h5;
    localparam S_STOP = 3'h6;

    // Address match, used by the write decodes and the receive-buffer read strobe below
    function hit;
        input [15:0] a;
        input [15:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // Parity of the first len+1 data bits
    function par_of;
        input [7:0] d;
        input [2:0] len;
        begin
            par_of = ^(d & (8'hff >> (3'h7 - len)));
        end
    endfunction

    reg  [7:0]  ccr_r;
    reg  [7:0]  ctl1_r;
    reg  [7:0]  hbaud_r;
    reg  [7:0]  lbaud_r;
    reg  [1:0]  ie_r;
    reg  [7:0]  pri_r;
    reg         ffen_r;
    reg         abden_r;
    reg         abddone_r;
    reg         rxovf_r;
    reg         pe_r;
    reg         oe_r;
    reg         fe_r;
    reg         brk_r;
    reg         wake_r;

    wire        swrst   = ~ctl1_r[`ASP_C1_SWRST_N];
    wire        wr_ccr  = bus_wr_i & hit(bus_addr_i, `ASP_A_CCR);
    wire        wr_c1   = bus_wr_i & hit(bus_addr_i, `ASP_A_CTL1);
    wire        wr_fftx = bus_wr_i & hit(bus_addr_i, `ASP_A_FFTX);
    wire        wr_ffrx = bus_wr_i & hit(bus_addr_i, `ASP_A_FFRX);
    wire        wr_ffct = bus_wr_i & hit(bus_addr_i, `ASP_A_FFCT);
    wire        wr_tx   = bus_wr_i & hit(bus_addr_i, `ASP_A_TXBUF);
    wire        rd_rx   = bus_rd_i & hit(bus_addr_i, `ASP_A_RXBUF);
    wire        addr_md = ccr_r[`ASP_CCR_ADDRMD];
    wire [2:0]  len     = ccr_r[2:0];

    // Queues: depth one in plain mode, sixteen in FIFO mode
    wire [7:0]  txf_dout;
    wire [7:0]  rxf_dout;
    wire [4:0]  txf_cnt;
    wire [4:0]  rxf_cnt;
    wire        txf_full;
    wire        txf_empty;
    wire        rxf_full;
    wire        rxf_empty;
    reg         tx_pop;
    reg         rx_push;
    wire        tx_rdy  = ffen_r ? ~txf_full : txf_empty; // RL7 RL5
    wire        rx_room = ffen_r ? ~rxf_full : rxf_empty;
    wire        rx_err  = pe_r | oe_r | fe_r | brk_r; // RL10
    wire        tx_push = wr_tx & tx_rdy;
    reg  [7:0]  rx_sh_r;
    wire        rx_pop  = rd_rx & ~rxf_empty;

    asp_fifo u_txf ( // RL17
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .clr_i     (swrst | (wr_fftx & bus_wdata_i[`ASP_FF_RST])),
        .push_i    (tx_push),
        .din_i     (bus_wdata_i[7:0]),
        .pop_i     (tx_pop),
        .dout_o    (txf_dout),
        .count_o   (txf_cnt),
        .full_o    (txf_full),
        .empty_o   (txf_empty)
    );

    asp_fifo u_rxf ( // RL17
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .clr_i     (swrst | (wr_ffrx & bus_wdata_i[`ASP_FF_RST])),
        .push_i    (rx_push),
        .din_i     (rx_sh_r),
        .pop_i     (rx_pop),
        .dout_o    (rxf_dout),
        .count_o   (rxf_cnt),
        .full_o    (rxf_full),
        .empty_o   (rxf_empty)
    );

    // Oversampling tick: eight per bit, so zero divider uses half rate
    wire [15:0] divider = {hbaud_r, lbaud_r}; // RL2
    wire [15:0] div_lim = (divider == 16'h0000) ? 16'h0001 : divider;
    reg  [15:0] bdiv_r;
    wire        tick    = (bdiv_r >= div_lim);
    always @(posedge ref_clk_i) begin
        if (!rst_n_i || swrst) begin
            bdiv_r <= 16'h0000;
        end else begin
            bdiv_r <= tick ? 16'h0000 : bdiv_r + 16'h0001; // RL1
        end
    end

    // Transmitter
    reg  [2:0]  tx_st_r;
    reg  [2:0]  tx_sub_r;
    reg  [3:0]  tx_bit_r;
    reg  [7:0]  tx_sh_r;
    reg         tx_par_r;
    reg         tx_wk_r;
    reg         tx_wake_used;
    wire        tx_bend = tick & (tx_sub_r == `ASP_OVS_LAST);
    always @(posedge ref_clk_i) begin
        tx_pop       <= 1'b0;
        tx_wake_used <= 1'b0;
        if (!rst_n_i || swrst) begin
            tx_st_r  <= S_IDLE;
            tx_sub_r <= 3'h0;
            tx_bit_r <= 4'h0;
            tx_sh_r  <= 8'h00;
            tx_par_r <= 1'b0;
            tx_wk_r  <= 1'b0;
        end else begin
            if (tick) begin
                tx_sub_r <= tx_sub_r + 3'h1;
            end
            case (tx_st_r)
                S_IDLE: begin
                    tx_sub_r <= 3'h0;
                    tx_bit_r <= 4'h0;
                    // Pop is a pulse; the queue count drops next cycle
                    // Launch on a tick so the start bit is a whole bit long
                    if (ctl1_r[`ASP_C1_TXEN] && !txf_empty && !tx_pop && tick) begin // RL6
                        tx_pop       <= 1'b1;
                        tx_sh_r      <= txf_dout;
                        tx_par_r     <= par_of(txf_dout, len) ^ ~ccr_r[`ASP_CCR_EVEN];
                        tx_wk_r      <= ctl1_r[`ASP_C1_TXWAKE];
                        tx_wake_used <= 1'b1;
                        // Idle-line mode marks an address with a long gap
                        if (!addr_md && ctl1_r[`ASP_C1_TXWAKE]) begin // RL12
                            tx_st_r <= S_GAP;
                        end else begin
                            tx_st_r <= S_STRT;
                        end
                    end
                end
                S_GAP: if (tx_bend) begin
                    tx_bit_r <= tx_bit_r + 4'h1;
                    if (tx_bit_r == `ASP_GAP_BITS - 4'h1) begin
                        tx_bit_r <= 4'h0;
                        tx_st_r  <= S_STRT;
                    end
                end
                S_STRT: if (tx_bend) begin
                    tx_st_r <= S_DATA;
                end
                S_DATA: if (tx_bend) begin
                    tx_sh_r  <= {1'b0, tx_sh_r[7:1]}; // RL18
                    tx_bit_r <= tx_bit_r + 4'h1;
                    if (tx_bit_r[2:0] == len) begin // RL3
                        tx_bit_r <= 4'h0;
                        tx_st_r  <= addr_md ? S_ADDR :
                                    (ccr_r[`ASP_CCR_PAREN] ? S_PAR : S_STOP);
                    end
                end
                S_ADDR: if (tx_bend) begin
                    tx_st_r <= ccr_r[`ASP_CCR_PAREN] ? S_PAR : S_STOP;
                end
                S_PAR: if (tx_bend) begin
                    tx_st_r <= S_STOP;
                end
                S_STOP: if (tx_bend) begin
                    tx_bit_r <= tx_bit_r + 4'h1;
                    if (tx_bit_r[0] == ccr_r[`ASP_CCR_STOP2]) begin
                        tx_st_r <= S_IDLE;
                    end
                end
                default: tx_st_r <= S_IDLE;
            endcase
        end
    end

    // Line level: NRZ, high at idle, gap and stop
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            serial_out_pin_o <= 1'b1;
        end else begin
            case (tx_st_r)
                S_STRT:  serial_out_pin_o <= 1'b0; // RL13
                S_DATA:  serial_out_pin_o <= tx_sh_r[0]; // RL18
                S_ADDR:  serial_out_pin_o <= tx_wk_r; // RL12
                S_PAR:   serial_out_pin_o <= tx_par_r; // RL3
                default: serial_out_pin_o <= 1'b1; // RL18
            endcase
        end
    end

    // Receiver, sampling at the centre of each oversampled bit
    reg  [2:0]  rx_st_r;
    reg  [2:0]  rx_sub_r;
    reg  [2:0]  rx_bit_r;
    reg         rx_in_r;
    reg         rx_prev_r;
    reg         rx_par_r;
    reg         rx_wk_r;
    reg  [6:0]  idle_cnt_r;
    reg         idle_seen_r;
    reg         set_pe;
    reg         set_fe;
    reg         set_brk;
    reg         set_oe;
    reg         set_wk;
    wire        rx_smp  = tick & (rx_sub_r == `ASP_CENTRE); // RL19
    always @(posedge ref_clk_i) begin
        rx_push <= 1'b0;
        set_pe  <= 1'b0;
        set_fe  <= 1'b0;
        set_brk <= 1'b0;
        set_oe  <= 1'b0;
        set_wk  <= 1'b0;
        if (!rst_n_i || swrst) begin
            rx_st_r     <= S_IDLE;
            rx_sub_r    <= 3'h0;
            rx_bit_r    <= 3'h0;
            rx_in_r     <= 1'b1;
            rx_prev_r   <= 1'b1;
            rx_sh_r     <= 8'h00;
            rx_par_r    <= 1'b0;
            rx_wk_r     <= 1'b0;
            idle_cnt_r  <= 7'h00;
            idle_seen_r <= 1'b0;
        end else begin
            rx_in_r   <= serial_in_pin_i;
            rx_prev_r <= rx_in_r;
            if (tick) begin
                rx_sub_r <= rx_sub_r + 3'h1;
            end
            case (rx_st_r)
                S_IDLE: begin
                    // Ten idle bit times flag an address frame
                    if (!rx_in_r) begin
                        idle_cnt_r <= 7'h00;
                    end else if (tick && idle_cnt_r != `ASP_IDLE_TICKS) begin
                        idle_cnt_r <= idle_cnt_r + 7'h01;
                    end else if (idle_cnt_r == `ASP_IDLE_TICKS) begin
                        idle_seen_r <= 1'b1; // RL12
                    end
                    if (ctl1_r[`ASP_C1_RXEN] && rx_prev_r && !rx_in_r) begin // RL6
                        rx_sub_r    <= 3'h0; // RL19
                        rx_bit_r    <= 3'h0;
                        rx_sh_r     <= 8'h00;
                        rx_wk_r     <= idle_seen_r;
                        idle_seen_r <= 1'b0;
                        rx_st_r     <= S_STRT;
                    end
                end
                S_STRT: if (rx_smp) begin
                    // A glitch shorter than half a bit is not a start
                    rx_st_r <= rx_in_r ? S_IDLE : S_DATA;
                end
                S_DATA: if (rx_smp) begin
                    rx_sh_r[rx_bit_r] <= rx_in_r; // RL18
                    rx_bit_r          <= rx_bit_r + 3'h1;
                    if (rx_bit_r == len) begin
                        rx_st_r <= addr_md ? S_ADDR :
                                   (ccr_r[`ASP_CCR_PAREN] ? S_PAR : S_STOP);
                    end
                end
                S_ADDR: if (rx_smp) begin
                    rx_wk_r <= rx_in_r; // RL12
                    rx_st_r <= ccr_r[`ASP_CCR_PAREN] ? S_PAR : S_STOP;
                end
                S_PAR: if (rx_smp) begin
                    rx_par_r <= rx_in_r;
                    rx_st_r  <= S_STOP;
                end
                S_STOP: if (rx_smp) begin
                    rx_st_r <= S_IDLE;
                    if (ccr_r[`ASP_CCR_PAREN] &&
                        (par_of(rx_sh_r, len) ^ ~ccr_r[`ASP_CCR_EVEN]) != rx_par_r) begin
                        set_pe <= 1'b1; // RL4
                    end
                    if (!rx_in_r) begin
                        set_fe  <= 1'b1; // RL4
                        set_brk <= (rx_sh_r == 8'h00) && !rx_par_r; // RL9
                    end
                    // Sleeping receivers keep only address frames
                    if (!ctl1_r[`ASP_C1_SLEEP] || rx_wk_r) begin // RL12
                        set_wk <= 1'b1;
                        if (rx_room) begin
                            rx_push <= 1'b1; // RL5
                        end else begin
                            set_oe  <= 1'b1; // RL4
                        end
                    end
                end
                default: rx_st_r <= S_IDLE;
            endcase
        end
    end

    // Bit rate detection: start bit low time is eight ticks
    reg  [18:0] abd_cnt_r;
    reg         abd_run_r;
    reg         abd_load;
    always @(posedge ref_clk_i) begin
        abd_load <= 1'b0;
        if (!rst_n_i || !abden_r || abddone_r) begin
            abd_cnt_r <= 19'h00000;
            abd_run_r <= 1'b0;
        end else if (abd_run_r) begin
            abd_cnt_r <= abd_cnt_r + 19'h00001;
            if (rx_in_r) begin
                abd_run_r <= 1'b0;
                abd_load  <= 1'b1; // RL16
            end
        end else if (rx_prev_r && !rx_in_r) begin
            abd_run_r <= 1'b1;
        end
    end
    wire [15:0] abd_div = (abd_cnt_r[18:3] == 16'h0000) ? 16'h0000 :
                          abd_cnt_r[18:3] - 16'h0001;

    // Register writes; hardware-set flags win over clears
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ccr_r     <= `ASP_RST_BYTE;
            ctl1_r    <= `ASP_RST_BYTE;
            hbaud_r   <= `ASP_RST_BYTE;
            lbaud_r   <= `ASP_RST_BYTE;
            ie_r      <= 2'h0;
            pri_r     <= `ASP_RST_BYTE;
            ffen_r    <= 1'b0;
            abden_r   <= 1'b0;
            abddone_r <= 1'b0;
            rxovf_r   <= 1'b0;
        end else begin
            // Upper data byte is ignored on every write
            if (wr_ccr) ccr_r <= bus_wdata_i[7:0]; // RL14
            if (wr_c1) begin
                ctl1_r <= bus_wdata_i[7:0];
            end else if (tx_wake_used) begin
                ctl1_r[`ASP_C1_TXWAKE] <= 1'b0;
            end
            if (bus_wr_i && hit(bus_addr_i, `ASP_A_CTL2)) begin
                ie_r <= bus_wdata_i[1:0]; // RL11
            end
            if (bus_wr_i && hit(bus_addr_i, `ASP_A_PRI)) pri_r <= bus_wdata_i[7:0];
            if (abd_load) begin
                {hbaud_r, lbaud_r} <= abd_div; // RL16
            end else begin
                if (bus_wr_i && hit(bus_addr_i, `ASP_A_HBAUD)) hbaud_r <= bus_wdata_i[7:0];
                if (bus_wr_i && hit(bus_addr_i, `ASP_A_LBAUD)) lbaud_r <= bus_wdata_i[7:0];
            end
            if (wr_fftx) ffen_r <= bus_wdata_i[`ASP_FF_EN]; // RL17
            if (wr_ffct) abden_r <= bus_wdata_i[`ASP_FC_ABDEN];
            if (abd_load) begin
                abddone_r <= 1'b1;
            end else if (wr_ffct && bus_wdata_i[`ASP_FC_ABDCLR]) begin
                abddone_r <= 1'b0;
            end
            if (set_oe && ffen_r) begin
                rxovf_r <= 1'b1;
            end else if (wr_ffrx && bus_wdata_i[`ASP_FF_OVFCLR]) begin
                rxovf_r <= 1'b0;
            end
        end
    end

    // Receive error and wake flags, cleared while the port is held
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            {pe_r, oe_r, fe_r, brk_r, wake_r} <= 5'h00;
        end else begin
            pe_r   <= set_pe  | (pe_r  & ~swrst); // RL4
            oe_r   <= set_oe  | (oe_r  & ~swrst); // RL4
            fe_r   <= set_fe  | (fe_r  & ~swrst); // RL4
            brk_r  <= set_brk | (brk_r & ~swrst); // RL9
            wake_r <= set_wk ? rx_wk_r : (wake_r & ~swrst);
        end
    end

    // Read data; debug buffer reads without popping
    reg [7:0] rd_byte;
    always @* begin
        case (bus_addr_i)
            `ASP_A_CCR:   rd_byte = ccr_r;
            `ASP_A_CTL1:  rd_byte = ctl1_r;
            `ASP_A_HBAUD: rd_byte = hbaud_r;
            `ASP_A_LBAUD: rd_byte = lbaud_r;
            `ASP_A_CTL2:  rd_byte = {tx_rdy, (tx_st_r == S_IDLE), 4'h0, ie_r}; // RL8
            `ASP_A_RXST:  rd_byte = {rx_err, ~rxf_empty, brk_r, fe_r, oe_r, pe_r,
                                     wake_r, 1'b0}; // RL9
            `ASP_A_RXEMU: rd_byte = rxf_dout;
            `ASP_A_RXBUF: rd_byte = rxf_dout;
            `ASP_A_FFTX:  rd_byte = {ffen_r, 2'h0, txf_cnt};
            `ASP_A_FFRX:  rd_byte = {rxovf_r, 2'h0, rxf_cnt};
            `ASP_A_FFCT:  rd_byte = {abddone_r, 6'h00, abden_r};
            `ASP_A_PRI:   rd_byte = pri_r;
            default:      rd_byte = 8'h00;
        endcase
    end

    // Registered read port and interrupt lines
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            bus_rdata_o <= 16'h0000;
            tx_irq_o    <= 1'b0;
            rx_irq_o    <= 1'b0;
        end else begin
            if (bus_rd_i) begin
                bus_rdata_o <= {8'h00, rd_byte}; // RL14
            end
            tx_irq_o <= ie_r[`ASP_C2_TXIE] & tx_rdy & ~swrst; // RL11
            // Break rides on the error enable, having none of its own
            rx_irq_o <= (ie_r[`ASP_C2_RXIE] & ~rxf_empty) |
                        (ctl1_r[`ASP_C1_RXERRIE] & rx_err); // RL11
        end
    end

endmodule
`default_nettype wire

// ### verification/asp_chk.sv
// Checker for asp_top, bound to its ports.
// Assumes a baud divider of 0 or 1, so a bit lasts 16 clocks.
`default_nettype none
module asp_chk (
    // Clock and reset
    input wire logic        ref_clk_i,
    input wire logic        rst_n_i,
    // Register port
    input wire logic [15:0] bus_addr_i,
    input wire logic        bus_wr_i,
    input wire logic        bus_rd_i,
    input wire logic [15:0] bus_wdata_i,
    input wire logic [15:0] bus_rdata_o,
    // Pins and requests
    input wire logic        serial_in_pin_i,
    input wire logic        serial_out_pin_o,
    input wire logic        tx_irq_o,
    input wire logic        rx_irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  shd_r [0:15];
    logic [15:0] exp_r;
    logic [7:0]  low_r;
    wire logic   rw_a = bus_addr_i inside {16'h7050, 16'h7052, 16'h7053, 16'h705f};
    // Shadow of plain storage, length of low runs
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 16; i++) shd_r[i] <= 8'h00;
        end else if (bus_wr_i) begin
            shd_r[bus_addr_i[3:0]] <= bus_wdata_i[7:0];
        end
        if (bus_rd_i) exp_r <= {8'h00, shd_r[bus_addr_i[3:0]]};
        low_r <= (serial_out_pin_o || !rst_n_i) ? 8'h00 : low_r + 8'h01;
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    AST_UPPER_ZERO: assert property (bus_rdata_o[15:8] == 8'h00)
        else $error("upper byte set");
    AST_READBACK: assert property (bus_rd_i && rw_a |=> bus_rdata_o == exp_r)
        else $error("stored byte lost");
    AST_UNMAPPED: assert property (bus_rd_i && bus_addr_i == 16'h7058 |=> bus_rdata_o == '0)
        else $error("unmapped read");
    AST_RD_HOLD: assert property (!bus_rd_i |=> $stable(bus_rdata_o))
        else $error("read data moved");
    AST_BIT_TIME: assert property ($rose(serial_out_pin_o) |-> low_r[3:0] == 4'h0 && low_r != 8'h00)
        else $error("bad low run");
    AST_STOP_MIN: assert property ($rose(serial_out_pin_o) |-> serial_out_pin_o [*8])
        else $error("short high run");
    AST_IDLE_RST: assert property (disable iff (1'b0) !rst_n_i |=> serial_out_pin_o)
        else $error("line low in reset");
    AST_IRQ_RST: assert property (disable iff (1'b0) !rst_n_i |=> !tx_irq_o && !rx_irq_o)
        else $error("irq in reset");
    COV_TX: cover property ($fell(serial_out_pin_o));
    COV_RX: cover property ($rose(rx_irq_o));
    COV_RD: cover property (bus_rd_i && bus_addr_i == 16'h7057);
endmodule
bind asp_top asp_chk i_asp_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
    .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o), .serial_in_pin_i(serial_in_pin_i),
    .serial_out_pin_o(serial_out_pin_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));
`default_nettype wire

// ### verification/asp_peer.sv
// Serial far end: sends frames, decodes received ones.
// Assumes 16 clocks a bit, 8 data bits, no parity, one stop bit.
`default_nettype none
module asp_peer (
    input  wire logic ref_clk_i,
    input  wire logic line_i,
    output var logic  line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] q [$];
    logic [7:0] sh;
    initial line_o = 1'b1;
    // Sender; a zero stop bit with zero data makes a break
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_o <= f[i];
            repeat (16) @(posedge ref_clk_i);
        end
        line_o <= 1'b1;
    endtask
    // Receiver samples bit centres
    initial forever begin
        @(negedge line_i);
        repeat (8) @(posedge ref_clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge ref_clk_i);
            sh[i] = line_i;
        end
        repeat (16) @(posedge ref_clk_i);
        q.push_back(sh);
    end
endmodule
`default_nettype wire

// ### verification/tb_async_serial_port_with_fifo.sv
// Testbench for asp_top with a serial far end.
// Assumes the checker binds itself; 250 MHz clock.
`default_nettype none
module tb_async_serial_port_with_fifo;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk_i, rst_n_i, bus_wr_i, bus_rd_i;
    logic [15:0] bus_addr_i, bus_wdata_i, v, x;
    wire logic [15:0] rdata;
    wire logic   sin, sout, txirq, rxirq;
    int          err_total, total_checks, seed;
    logic [7:0]  b [3];
    logic [15:0] rwa [4] = '{16'h705f, 16'h7050, 16'h7052, 16'h7053};
    asp_top i_asp_top (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_addr_i(bus_addr_i),
        .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_wdata_i(bus_wdata_i),
        .bus_rdata_o(rdata), .serial_in_pin_i(sin), .serial_out_pin_o(sout),
        .tx_irq_o(txirq), .rx_irq_o(rxirq));
    asp_peer i_asp_peer (.ref_clk_i(ref_clk_i), .line_i(sout), .line_o(sin));
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Strobe held for one edge
    task wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        bus_addr_i <= a;
        bus_wdata_i <= d;
        bus_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        bus_wr_i <= 1'b0;
    endtask
    task rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge ref_clk_i);
        bus_addr_i <= a;
        bus_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        bus_rd_i <= 1'b0;
        #1 d = rdata;
    endtask
    function logic [15:0] stat_exp(input logic brk);
        return brk ? 16'h00b0 : 16'h0040;
    endfunction
    task tally_and_finish;
        $display("Checks %0d, errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Watchdog far past the frames
    initial begin
        repeat (40000) @(posedge ref_clk_i);
        err_total++;
        tally_and_finish;
    end
    initial begin
        seed = 32'hb9f28c45;
        {rst_n_i, bus_wr_i, bus_rd_i, bus_addr_i, bus_wdata_i} = '0;
        repeat (16) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        // Junk in the upper byte
        for (int i = 0; i < 4; i++) begin
            x = $random(seed);
            wr(rwa[i], x);
            rd(rwa[i], v);
            chk(v, {8'h00, x[7:0]});
        end
        rd(16'h7058, v);
        chk(v, 16'h0000);
        // 8 bits, divider 1, both paths, queue on
        wr(16'h7050, 16'h0007);
        wr(16'h7052, 16'h0000);
        wr(16'h7053, 16'h0001);
        wr(16'h7051, 16'h0023);
        wr(16'h7054, 16'h0003);
        wr(16'h705a, 16'h0080);
        for (int i = 0; i < 3; i++) begin
            b[i] = $random(seed);
            wr(16'h7059, {8'ha5, b[i]});
        end
        for (int n = 0; n < 3000 && i_asp_peer.q.size() < 3; n++) @(posedge ref_clk_i);
        for (int i = 0; i < 3; i++) chk({8'h00, i_asp_peer.q.pop_front()}, {8'h00, b[i]});
        repeat (16) @(posedge ref_clk_i);
        rd(16'h7054, v);
        chk(v, 16'h00c3);
        chk(16'(txirq), 16'h0001);
        // One clean frame, then a break
        for (int k = 0; k < 2; k++) begin
            b[0] = $random(seed);
            i_asp_peer.send(k ? 8'h00 : b[0], k ? 1'b0 : 1'b1);
            repeat (4) @(posedge ref_clk_i);
            rd(16'h7055, v);
            if (k == 0) chk(16'(rxirq), 16'h0001);
            chk(v & (k ? 16'h00b0 : 16'h00fc), stat_exp(k[0]));
            rd(16'h7057, v);
            if (k == 0) chk(v, {8'h00, b[0]});
        end
        tally_and_finish;
    end
endmodule
`default_nettype wire
